// File: hdl/shp_pkg.sv
`default_nettype none
package shp_pkg;
   // ==========================================
   // widths
   localparam int ADDR_W     = 7;
   localparam int DATA_W     = 32;
   localparam int HALF_W     = 16;
   localparam int CSR_IDX_W  = 4;
   // ==========================================
   // address map (word address, bit 0 selects half in 16-bit mode)
   localparam logic [6:0] ADDR_RXQ     = 7'h00;
   localparam logic [6:0] ADDR_TXQ     = 7'h10;
   localparam logic [6:0] ADDR_CSR_LO  = 7'h20;
   localparam logic [6:0] ADDR_CSR_HI  = 7'h3F;
   localparam logic [6:0] ADDR_ENDIAN  = 7'h32;
   localparam int         QSEL_HI      = 6;
   localparam int         QSEL_LO      = 2;
   localparam int         QDIR_BIT     = 1;
   localparam int         HALF_BIT     = 0;
   localparam int         CSR_IDX_LO   = 1;
   // ==========================================
   // constants
   localparam logic [31:0] ENDIAN_WORD  = 32'h8765_4321;
   localparam logic [31:0] CSR_RESET    = 32'h0000_0000;
   localparam logic [15:0] PULL_LEVEL   = 16'h0000;
   localparam int          FIFO_DEPTH   = 4;
   // ==========================================
   // access decode
   typedef enum logic [1:0] {
      SHP_TGT_RXQ  = 2'b00,
      SHP_TGT_TXQ  = 2'b01,
      SHP_TGT_CSR  = 2'b10,
      SHP_TGT_NONE = 2'b11
   } shp_tgt_t;
   typedef enum logic [1:0] {
      SHP_ST_IDLE  = 2'b00,
      SHP_ST_READ  = 2'b01,
      SHP_ST_WRITE = 2'b10
   } shp_state_t;
endpackage
`default_nettype wire

// File: hdl/shp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module shp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic [PW-1:0]    next_wr_ptr;
   logic [PW-1:0]    next_rd_ptr;
   logic [PW:0]      next_count;
   logic             push;
   logic             pop;
   // ==========================================
   // flags
   assign in_ready  = (count < (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // ==========================================
   // next state
   always_comb begin
      next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   // head word always visible from storage register
   assign out_data = mem[rd_ptr];
endmodule
`default_nettype wire

// File: hdl/shp_host_port.sv
`timescale 1ns/100ps
`default_nettype none
module shp_host_port #(
   parameter int CSR_COUNT = 16
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [shp_pkg::ADDR_W-1:0] addr,
   input  wire logic [shp_pkg::DATA_W-1:0] data_in,
   output logic      [shp_pkg::DATA_W-1:0] data_out,
   output logic      [shp_pkg::DATA_W-1:0] data_oe_n,
   output logic      [shp_pkg::HALF_W-1:0] upper_pull_en,
   input  wire logic                       read_strobe_n,
   input  wire logic                       write_strobe_n,
   input  wire logic                       device_select_n,
   input  wire logic                       queue_select,
   input  wire logic                       bus_width_strap,
   input  wire logic                       big_endian,
   input  wire logic                       low_power,
   output logic                            wake,
   output logic                            bus_is_32,
   input  wire logic                       rxq_valid,
   output logic                            rxq_ready,
   input  wire logic [shp_pkg::DATA_W-1:0] rxq_data,
   output logic                            txq_valid,
   input  wire logic                       txq_ready,
   output logic      [shp_pkg::DATA_W-1:0] txq_data
);
   import shp_pkg::*;

   // ==========================================
   // functions
   function automatic shp_tgt_t decode(input logic [ADDR_W-1:0] a, input logic qs);
      if (qs) begin
         decode = a[QDIR_BIT] ? SHP_TGT_TXQ : SHP_TGT_RXQ;
      end else if (a < ADDR_TXQ) begin
         decode = SHP_TGT_RXQ;
      end else if (a < ADDR_CSR_LO) begin
         decode = SHP_TGT_TXQ;
      end else if (a <= ADDR_CSR_HI) begin
         decode = SHP_TGT_CSR;
      end else begin
         decode = SHP_TGT_NONE;
      end
   endfunction
   function automatic logic [DATA_W-1:0] swap(input logic [DATA_W-1:0] w, input logic be);
      swap = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
   endfunction

   // ==========================================
   // state
   shp_state_t             state;
   shp_state_t             next_state;
   logic                   width32;
   logic                   next_width32;
   logic                   strap_taken;
   logic                   next_strap_taken;
   logic                   read_seen;
   logic                   next_read_seen;
   logic [DATA_W-1:0]      rd_word;
   logic [DATA_W-1:0]      next_rd_word;
   logic [DATA_W-1:0]      wr_hold;
   logic [DATA_W-1:0]      next_wr_hold;
   logic [DATA_W-1:0]      dout;
   logic [DATA_W-1:0]      next_dout;
   logic                   drive;
   logic                   next_drive;
   logic                   wake_q;
   logic                   next_wake;
   logic [DATA_W-1:0]      csr [CSR_COUNT];
   logic                   fifo_in_valid;
   logic                   fifo_in_ready;
   logic [DATA_W-1:0]      fifo_in_data;
   logic                   rd_cyc;
   logic                   wr_cyc;
   logic                   half_hi;
   shp_tgt_t               tgt;
   logic [CSR_IDX_W-1:0]   csr_idx;
   logic [DATA_W-1:0]      host_word;
   logic [DATA_W-1:0]      csr_wr_word;
   logic                   csr_we;
   logic                   is_endian;

   // ==========================================
   // access qualification
   assign rd_cyc  = !device_select_n && !read_strobe_n;
   assign wr_cyc  = !device_select_n && !write_strobe_n;
   assign tgt     = decode(addr, queue_select);
   assign half_hi = !width32 && addr[HALF_BIT];
   assign csr_idx = addr[CSR_IDX_LO +: CSR_IDX_W];
   assign is_endian = (addr[ADDR_W-1:CSR_IDX_LO] == ADDR_ENDIAN[ADDR_W-1:CSR_IDX_LO]);

   // incoming word assembled from halves in 16-bit mode
   always_comb begin
      host_word = data_in;
      if (!width32) begin
         host_word = half_hi ? {data_in[HALF_W-1:0], wr_hold[HALF_W-1:0]}
                             : {wr_hold[DATA_W-1:HALF_W], data_in[HALF_W-1:0]};
      end
   end

   // ==========================================
   // cycle control
   always_comb begin
      next_state       = state;
      next_width32     = width32;
      next_strap_taken = 1'b1;
      next_read_seen   = read_seen;
      next_rd_word     = rd_word;
      next_wr_hold     = wr_hold;
      next_dout        = dout;
      next_drive       = 1'b0;
      next_wake        = 1'b0;
      fifo_in_valid    = 1'b0;
      fifo_in_data     = swap(host_word, big_endian);
      csr_we           = 1'b0;
      csr_wr_word      = swap(host_word, big_endian);
      rxq_ready        = 1'b0;
      if (!strap_taken) begin
         next_width32 = bus_width_strap;
      end
      if (low_power && wr_cyc) begin
         next_wake      = 1'b1;
         next_read_seen = 1'b0;
      end
      case (state)
         SHP_ST_IDLE: begin
            if (rd_cyc && !low_power) begin
               next_state     = SHP_ST_READ;
               next_read_seen = 1'b1;
               next_drive     = 1'b1;
               if (!half_hi) begin
                  case (tgt)
                     SHP_TGT_RXQ: begin
                        next_rd_word = rxq_valid ? swap(rxq_data, big_endian) : '0;
                        rxq_ready    = rxq_valid && width32;
                     end
                     SHP_TGT_CSR: next_rd_word = is_endian ? swap(ENDIAN_WORD, big_endian)
                                                           : swap(csr[csr_idx], big_endian);
                     default:     next_rd_word = '0;
                  endcase
               end
               next_dout = half_hi ? {{HALF_W{1'b0}}, rd_word[DATA_W-1:HALF_W]}
                                   : next_rd_word;
               if (half_hi && tgt == SHP_TGT_RXQ) begin
                  rxq_ready = rxq_valid;
               end
            end else if (wr_cyc && !low_power && read_seen) begin
               next_state = SHP_ST_WRITE;
               if (!width32 && !half_hi) begin
                  next_wr_hold = host_word;
               end else begin
                  fifo_in_valid = (tgt == SHP_TGT_TXQ);
                  csr_we        = (tgt == SHP_TGT_CSR) && !queue_select && !is_endian;
               end
            end
         end
         SHP_ST_READ: begin
            next_drive = rd_cyc;
            if (!rd_cyc) begin
               next_state = SHP_ST_IDLE;
            end
         end
         SHP_ST_WRITE: begin
            if (!wr_cyc) begin
               next_state = SHP_ST_IDLE;
            end
         end
         default: next_state = SHP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state       <= SHP_ST_IDLE;
         width32     <= 1'b0;
         strap_taken <= 1'b0;
         read_seen   <= 1'b0;
         rd_word     <= '0;
         wr_hold     <= '0;
         dout        <= '0;
         drive       <= 1'b0;
         wake_q      <= 1'b0;
      end else begin
         state       <= next_state;
         width32     <= next_width32;
         strap_taken <= next_strap_taken;
         read_seen   <= next_read_seen;
         rd_word     <= next_rd_word;
         wr_hold     <= next_wr_hold;
         dout        <= next_dout;
         drive       <= next_drive;
         wake_q      <= next_wake;
      end
   end

   // ==========================================
   // control registers
   genvar gi;
   generate
      for (gi = 0; gi < CSR_COUNT; gi++) begin : g_csr
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               csr[gi] <= CSR_RESET;
            end else if (csr_we && csr_idx == CSR_IDX_W'(gi)) begin
               csr[gi] <= csr_wr_word;
            end
         end
      end
   endgenerate

   // ==========================================
   // transmit queue buffer
   shp_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_txq (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (txq_valid),
      .out_ready (txq_ready),
      .out_data  (txq_data)
   );

   // ==========================================
   // pins
   assign data_out      = dout;
   assign data_oe_n     = drive ? '0 : '1;
   assign upper_pull_en = width32 ? PULL_LEVEL : ~PULL_LEVEL;
   assign wake          = wake_q;
   assign bus_is_32     = width32;
endmodule
`default_nettype wire

// File: testbench/shp_host_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker
module shp_host_port_chk #(parameter int CSR_COUNT = 16) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [31:0] data_out,
   input wire logic [31:0] data_oe_n,
   input wire logic [15:0] upper_pull_en,
   input wire logic        read_strobe_n,
   input wire logic        write_strobe_n,
   input wire logic        device_select_n,
   input wire logic        low_power,
   input wire logic        wake,
   input wire logic        bus_is_32,
   input wire logic        txq_valid,
   input wire logic        txq_ready,
   input wire logic [31:0] txq_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_width_held: assert property (
      !$past(rst) && !$past(rst, 2) |-> $stable(bus_is_32)) else $error("width moved");
   chk_pull_mode: assert property (
      !$past(rst) && $stable(bus_is_32) |-> upper_pull_en == {16{!bus_is_32}})
      else $error("pull mode wrong");
   chk_read_cause: assert property (
      $fell(data_oe_n[0]) |-> !$past(device_select_n) && !$past(read_strobe_n)
      && !$past(low_power)) else $error("drive without read");
   chk_oe_release: assert property (
      $rose(read_strobe_n) |-> ##[1:2] (&data_oe_n)) else $error("bus not released");
   chk_data_stands: assert property (
      !data_oe_n[0] && !$past(data_oe_n[0]) |-> $stable(data_out)) else $error("data moved");
   chk_wake_cause: assert property (
      wake |-> $past(low_power) && !$past(device_select_n) && !$past(write_strobe_n))
      else $error("wake without write");
   chk_wake_seen: assert property (
      low_power && !device_select_n && !write_strobe_n |=> wake) else $error("no wake");
   chk_tx_hold: assert property (
      txq_valid && !txq_ready |=> txq_valid && $stable(txq_data)) else $error("tx dropped");
endmodule
bind shp_host_port shp_host_port_chk #(.CSR_COUNT(CSR_COUNT)) u_chk (
   .clk, .rst, .data_out, .data_oe_n, .upper_pull_en, .read_strobe_n, .write_strobe_n,
   .device_select_n, .low_power, .wake, .bus_is_32, .txq_valid, .txq_ready, .txq_data);
`default_nettype wire

// File: testbench/shp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host processor on the sram-style port
module shp_host_model (
   input  wire logic        clk,
   input  wire logic [31:0] data_out,
   output logic      [6:0]  addr,
   output logic      [31:0] data_in,
   output logic             read_strobe_n,
   output logic             write_strobe_n,
   output logic             device_select_n,
   output logic             queue_select
);
   initial {read_strobe_n, write_strobe_n, device_select_n, queue_select, addr, data_in} = '1;
   // request held two edges, answer taken at the second
   task acc(input logic w, input logic sel, input logic qs, input logic [6:0] a,
            input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      #1;
      addr = a;
      data_in = w ? d : ~data_in;
      queue_select = qs;
      device_select_n = ~sel;
      read_strobe_n = w;
      write_strobe_n = ~w;
      repeat (2) @(posedge clk);
      q = data_out;
      #1;
      {read_strobe_n, write_strobe_n, device_select_n} = 3'b111;
      data_in = ~data_in;
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench top
module testbench;
   import shp_pkg::*;
   logic        clk, rst, bus_width_strap, big_endian, low_power, wake, bus_is_32;
   logic        rxq_valid, rxq_ready, txq_valid, txq_ready, queue_select;
   logic        read_strobe_n, write_strobe_n, device_select_n;
   logic [31:0] data_in, data_out, data_oe_n, rxq_data, txq_data, q;
   logic [15:0] upper_pull_en;
   logic [6:0]  addr;
   int          n_errors, total_checks, wakes, rx_pops;
   shp_host_port dut (.clk, .rst, .addr, .data_in, .data_out, .data_oe_n, .upper_pull_en,
      .read_strobe_n, .write_strobe_n, .device_select_n, .queue_select, .bus_width_strap,
      .big_endian, .low_power, .wake, .bus_is_32, .rxq_valid, .rxq_ready, .rxq_data,
      .txq_valid, .txq_ready, .txq_data);
   shp_host_model h (.clk, .data_out, .addr, .data_in, .read_strobe_n, .write_strobe_n,
      .device_select_n, .queue_select);
   always #50 clk = ~clk;
   always @(posedge clk) if (wake === 1'b1) wakes++;
   always @(posedge clk) if (rxq_ready === 1'b1) rx_pops++;
   task ck(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         n_errors++;
      end
   endtask
   task wr(input logic [6:0] a, input logic [31:0] d);
      h.acc(1'b1, 1'b1, 1'b0, a, d, q);
   endtask
   task rd(input logic [6:0] a);
      h.acc(1'b0, 1'b1, 1'b0, a, 32'h0, q);
   endtask
   task drain(input int n, input logic [31:0] b);
      int k;
      k = 0;
      txq_ready = 1'b1;
      repeat (8) begin
         @(posedge clk);
         if (txq_valid === 1'b1) begin
            ck("tx word", b + k, txq_data);
            k++;
         end
      end
      #1 txq_ready = 1'b0;
      ck("tx count", n, k);
   endtask
   task do_reset(input logic s);
      rst = 1'b1;
      bus_width_strap = s;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      #1 bus_width_strap = ~s;
      ck("width", s, bus_is_32);
      ck("pulls", {16{~s}}, upper_pull_en);
      ck("idle oe", '1, data_oe_n);
   endtask
   task t_gate;
      wr(ADDR_TXQ, 32'hDEAD_0001);
      ck("early write", 0, txq_valid);
      rd(ADDR_CSR_LO + 7'h2);
      ck("csr reset", CSR_RESET, q);
      wr(ADDR_CSR_LO + 7'h2, 32'hA5A5_5A5A);
      rd(ADDR_CSR_LO + 7'h2);
      ck("csr back", 32'hA5A5_5A5A, q);
      rd(ADDR_ENDIAN);
      ck("endian", ENDIAN_WORD, q);
      rd(7'h40);
      ck("unmapped", 0, q);
      h.acc(1'b1, 1'b0, 1'b0, ADDR_TXQ, 32'h0BAD_0BAD, q);
      ck("no select", 0, txq_valid);
      $display("gate test done");
   endtask
   task t_queue;
      for (int i = 0; i < 5; i++)
         h.acc(1'b1, 1'b1, i[0], i[0] ? 7'h7E : ADDR_TXQ, 32'h1000_0000 + i, q);
      drain(4, 32'h1000_0000);
      rxq_valid = 1'b1;
      rxq_data = 32'h1122_3344;
      rx_pops = 0;
      rd(ADDR_RXQ);
      ck("rx word", 32'h1122_3344, q);
      big_endian = 1'b1;
      h.acc(1'b0, 1'b1, 1'b1, 7'h7C, 32'h0, q);
      ck("rx swap", 32'h4433_2211, q);
      ck("rx pops", 2, rx_pops);
      big_endian = 1'b0;
      rxq_valid = 1'b0;
      $display("queue test done");
   endtask
   task t_power;
      low_power = 1'b1;
      wakes = 0;
      h.acc(1'b1, 1'b0, 1'b0, ADDR_ENDIAN, 32'h0, q);
      ck("wake unselected", 0, wakes);
      wr(ADDR_ENDIAN, 32'h0);
      ck("wake", 1, wakes > 0);
      low_power = 1'b0;
      wr(ADDR_TXQ, 32'h2000_0000);
      ck("write after wake", 0, txq_valid);
      rd(ADDR_ENDIAN);
      wr(ADDR_TXQ, 32'h2000_0000);
      drain(1, 32'h2000_0000);
      $display("power test done");
   endtask
   task t_half;
      do_reset(1'b0);
      rd(ADDR_ENDIAN);
      ck("endian lo", ENDIAN_WORD[15:0], q[15:0]);
      wr(ADDR_TXQ, 32'h0000_5678);
      wr(ADDR_TXQ + 7'h1, 32'h0000_1234);
      drain(1, 32'h1234_5678);
      rxq_valid = 1'b1;
      rxq_data = 32'hCAFE_F00D;
      rx_pops = 0;
      rd(ADDR_RXQ);
      ck("rx lo", 16'hF00D, q[15:0]);
      ck("rx lo pop", 0, rx_pops);
      rd(ADDR_RXQ + 7'h1);
      ck("rx hi", 16'hCAFE, q[15:0]);
      ck("rx hi pop", 1, rx_pops);
      rxq_valid = 1'b0;
      $display("half test done");
   endtask
   task conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {clk, big_endian, low_power, rxq_valid, txq_ready} = '0;
      rxq_data = 32'h0;
      n_errors = 0;
      total_checks = 0;
      wakes = 0;
      do_reset(1'b1);
      t_gate;
      t_queue;
      t_power;
      t_half;
      conclude;
   end
   initial begin
      #400_000;
      n_errors++;
      conclude;
   end
endmodule
`default_nettype wire
